//--- rtl/fir_regs.v
// Feature inquiry register bank with a classic Wishbone slave port.
//
// Local design decision: the Wishbone register port.
`timescale 1ns/100ps
`include "fir_map.vh"

module fir_regs #(
    parameter COLOR_VARIANT = 0,
    parameter [63:0] WB_OFF_MAP = 64'h0000_0000_0000_0000,
    parameter [31:0] VENDOR_PTR = `FIR_VENDOR_PTR_DEF,
    parameter [31:0] PIO_PTR = `FIR_PIO_PTR_DEF,
    parameter [31:0] STROBE_PTR = `FIR_STROBE_PTR_DEF
) (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [`FIR_ADR_W-1:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output wire [31:0] wb_dat_o,
    output wire wb_ack_o,
    output wire [2:0] video_format_o,
    output wire [2:0] video_mode_o,
    output wire presence_changed_o
);

    // ------------------------------------------------------------------------
    // Bus state machine
    // ------------------------------------------------------------------------
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_ACK = 2'b10;

    reg [1:0] state_q;
    reg [1:0] state_d;
    reg ack_q;
    reg ack_d;
    reg [31:0] dat_q;
    reg [31:0] dat_d;

    // ------------------------------------------------------------------------
    // Control and presence state
    // ------------------------------------------------------------------------
    reg [2:0] fmt_q;
    reg [2:0] fmt_d;
    reg [2:0] mode_q;
    reg [2:0] mode_d;
    reg changed_q;
    reg changed_d;
    reg [`FIR_HI_FIELDS-1:0] high_q;
    reg [`FIR_LO_FIELDS-1:0] low_q;
    reg [`FIR_OPT_FIELDS-1:0] opt_q;

    wire [`FIR_HI_FIELDS-1:0] high_now;
    wire [`FIR_LO_FIELDS-1:0] low_now;
    wire [`FIR_OPT_FIELDS-1:0] opt_now;
    wire [31:0] high_word;
    wire [31:0] low_word;
    wire [31:0] opt_word;
    wire take;
    wire wr_sel;
    wire wr_stat;
    wire pres_moved;

    // Address compare used by both the read mux and the write strobes.
    function hit;
        input [`FIR_ADR_W-1:0] adr;
        input [`FIR_ADR_W-1:0] off;
        begin
            hit = (adr[`FIR_ADR_W-1:2] == off[`FIR_ADR_W-1:2]);
        end
    endfunction

    // ------------------------------------------------------------------------
    // Presence source
    // ------------------------------------------------------------------------
    fir_presence #(
        .COLOR_VARIANT(COLOR_VARIANT),
        .WB_OFF_MAP(WB_OFF_MAP)
    ) u_presence (
        .format_i(fmt_q),
        .mode_i(mode_q),
        .high_o(high_now),
        .low_o(low_now),
        .opt_o(opt_now)
    );

    // Presence follows the selection one cycle after it is written.
    always @(posedge clk_i) begin
        if (rst_i) begin
            high_q <= {`FIR_HI_FIELDS{1'b0}};
            low_q <= {`FIR_LO_FIELDS{1'b0}};
            opt_q <= {`FIR_OPT_FIELDS{1'b0}};
        end else begin
            high_q <= high_now; // R2
            low_q <= low_now;
            opt_q <= opt_now;
        end
    end

    // ------------------------------------------------------------------------
    // Bit order: presence bit n sits at data bit 31-n
    // ------------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < 32; i = i + 1) begin : g_order
            if (i < `FIR_HI_FIELDS) begin : g_hi
                assign high_word[31-i] = high_q[i]; // R12 R3
            end else begin : g_hi_rsv
                assign high_word[31-i] = 1'b0; // R3
            end
            if (i < `FIR_LO_FIELDS) begin : g_lo
                assign low_word[31-i] = low_q[i]; // R12 R7
            end else begin : g_lo_rsv
                assign low_word[31-i] = 1'b0; // R12
            end
            if (i < `FIR_OPT_FIELDS) begin : g_opt
                assign opt_word[31-i] = opt_q[i]; // R12 R8
            end else begin : g_opt_rsv
                assign opt_word[31-i] = 1'b0; // R8
            end
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------------------
    assign take = wb_cyc_i && wb_stb_i && state_q[0];
    // Only the two control words accept writes; inquiry words drop them.
    assign wr_sel = take && wb_we_i && hit(wb_adr_i, `FIR_OFF_VIDEO_SEL); // R13
    assign wr_stat = take && wb_we_i && hit(wb_adr_i, `FIR_OFF_STATUS); // R13
    assign pres_moved = (high_now != high_q) || (low_now != low_q) ||
        (opt_now != opt_q);

    always @* begin
        state_d = state_q;
        ack_d = 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (take) begin
                    state_d = ST_ACK;
                    ack_d = 1'b1;
                end
            end
            ST_ACK: begin
                state_d = ST_IDLE;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------------
    always @* begin
        dat_d = dat_q;
        if (take) begin
            dat_d = `FIR_ZERO_WORD;
            if (!wb_we_i) begin
                if (hit(wb_adr_i, `FIR_OFF_FEAT_HIGH)) begin
                    dat_d = high_word; // R1 R3
                end else if (hit(wb_adr_i, `FIR_OFF_FEAT_LOW)) begin
                    dat_d = low_word; // R1 R7
                end else if (hit(wb_adr_i, `FIR_OFF_OPT_FUNC)) begin
                    dat_d = opt_word; // R1 R8
                end else if (hit(wb_adr_i, `FIR_OFF_VENDOR_PTR)) begin
                    dat_d = VENDOR_PTR; // R9
                end else if (hit(wb_adr_i, `FIR_OFF_PIO_PTR)) begin
                    dat_d = PIO_PTR; // R10
                end else if (hit(wb_adr_i, `FIR_OFF_STROBE_PTR)) begin
                    dat_d = STROBE_PTR; // R11
                end else if (hit(wb_adr_i, `FIR_OFF_VIDEO_SEL)) begin
                    dat_d[`FIR_SEL_FMT_LSB +: `FIR_SEL_FMT_W] = fmt_q;
                    dat_d[`FIR_SEL_MODE_LSB +: `FIR_SEL_MODE_W] = mode_q;
                end else if (hit(wb_adr_i, `FIR_OFF_STATUS)) begin
                    dat_d[`FIR_STAT_CHANGED] = changed_q;
                    dat_d[`FIR_STAT_VARIANT] = (COLOR_VARIANT != 0);
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // Control writes
    // ------------------------------------------------------------------------
    always @* begin
        fmt_d = fmt_q;
        mode_d = mode_q;
        if (wr_sel && wb_sel_i[`FIR_SEL_FMT_LANE]) begin
            fmt_d = wb_dat_i[`FIR_SEL_FMT_LSB +: `FIR_SEL_FMT_W]; // R2
        end
        if (wr_sel && wb_sel_i[`FIR_SEL_MODE_LANE]) begin
            mode_d = wb_dat_i[`FIR_SEL_MODE_LSB +: `FIR_SEL_MODE_W]; // R2
        end
    end

    // A presence change in the clearing cycle keeps the flag set.
    always @* begin
        changed_d = changed_q;
        if (wr_stat && wb_sel_i[`FIR_STAT_LANE] && wb_dat_i[`FIR_STAT_CHANGED]) begin
            changed_d = 1'b0;
        end
        if (pres_moved) begin
            changed_d = 1'b1;
        end
    end

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ST_IDLE;
            ack_q <= 1'b0;
            dat_q <= `FIR_ZERO_WORD;
            fmt_q <= `FIR_SEL_FMT_RST;
            mode_q <= `FIR_SEL_MODE_RST;
            changed_q <= 1'b0;
        end else begin
            state_q <= state_d;
            ack_q <= ack_d;
            dat_q <= dat_d;
            fmt_q <= fmt_d;
            mode_q <= mode_d;
            changed_q <= changed_d;
        end
    end

    assign wb_dat_o = dat_q;
    assign wb_ack_o = ack_q;
    assign video_format_o = fmt_q;
    assign video_mode_o = mode_q;
    assign presence_changed_o = changed_q;

endmodule // fir_regs

//--- inc/fir_map.vh
// Register map, field positions and reset values of the feature inquiry bank.
// Function
// R1: Presence bits read one when feature exists.
// R2: Presence follows selected video format and mode.
// R3: High register bits 0-15 features, 16-31 reserved.
// R4: Brightness, shutter, gain, trigger, frame rate present.
// R5: White balance bit present only on colour variant.
// R6: Unsupported high register features always read zero.
// R7: Low register zoom to capture quality read zero.
// R8: Parallel I/O and strobe present, serial absent.
// R9: Vendor space pointer returns quadlet offset.
// R10: Parallel I/O pointer returns quadlet offset.
// R11: Strobe pointer returns quadlet offset.
// R12: Bit 0 is MSB; reserved bits read zero.
// R13: Inquiry registers are read-only, writes ignored.
`ifndef FIR_MAP_VH
`define FIR_MAP_VH

// ----------------------------------------------------------------------------
// Byte addresses
// ----------------------------------------------------------------------------
`define FIR_ADR_W 12
`define FIR_OFF_FEAT_HIGH 12'h404
`define FIR_OFF_FEAT_LOW 12'h408
`define FIR_OFF_OPT_FUNC 12'h40C
`define FIR_OFF_VENDOR_PTR 12'h480
`define FIR_OFF_PIO_PTR 12'h484
`define FIR_OFF_STROBE_PTR 12'h48C
`define FIR_OFF_VIDEO_SEL 12'h4F0
`define FIR_OFF_STATUS 12'h4F4

// ----------------------------------------------------------------------------
// Presence bit numbers, counted from the most significant bit
// ----------------------------------------------------------------------------
`define FIR_HI_BRIGHTNESS 0
`define FIR_HI_WHITE_BAL 3
`define FIR_HI_SHUTTER 7
`define FIR_HI_GAIN 8
`define FIR_HI_TRIGGER 12
`define FIR_HI_FRAME_RATE 15
`define FIR_HI_FIELDS 16
`define FIR_OPT_PARALLEL_IO 1
`define FIR_OPT_SERIAL_IO 2
`define FIR_OPT_STROBE 3
`define FIR_OPT_FIELDS 4
`define FIR_LO_FIELDS 18

// ----------------------------------------------------------------------------
// Video select and status fields, plain data bit positions
// ----------------------------------------------------------------------------
`define FIR_SEL_FMT_LSB 8
`define FIR_SEL_FMT_W 3
`define FIR_SEL_MODE_LSB 0
`define FIR_SEL_MODE_W 3
`define FIR_SEL_FMT_RST 3'h7
`define FIR_SEL_MODE_RST 3'h0
`define FIR_SEL_FMT_LANE 1
`define FIR_SEL_MODE_LANE 0
`define FIR_STAT_LANE 0
`define FIR_STAT_CHANGED 0
`define FIR_STAT_VARIANT 1

// ----------------------------------------------------------------------------
// Default pointer values
// ----------------------------------------------------------------------------
`define FIR_VENDOR_PTR_DEF 32'h0000_1000
`define FIR_PIO_PTR_DEF 32'h0000_1100
`define FIR_STROBE_PTR_DEF 32'h0000_1200
`define FIR_ZERO_WORD 32'h0000_0000

`endif

//--- rtl/fir_presence.v
// Presence vectors for the selected video format and mode.
`timescale 1ns/100ps
`include "fir_map.vh"

module fir_presence #(
    parameter COLOR_VARIANT = 0,
    parameter [63:0] WB_OFF_MAP = 64'h0000_0000_0000_0000
) (
    input wire [2:0] format_i,
    input wire [2:0] mode_i,
    output reg [`FIR_HI_FIELDS-1:0] high_o,
    output reg [`FIR_LO_FIELDS-1:0] low_o,
    output reg [`FIR_OPT_FIELDS-1:0] opt_o
);

    // Index n of each vector is presence bit n; the bank flips it to MSB order.
    always @* begin
        high_o = {`FIR_HI_FIELDS{1'b0}}; // R6
        high_o[`FIR_HI_BRIGHTNESS] = 1'b1; // R4
        high_o[`FIR_HI_SHUTTER] = 1'b1; // R4
        high_o[`FIR_HI_GAIN] = 1'b1; // R4
        high_o[`FIR_HI_TRIGGER] = 1'b1; // R4
        high_o[`FIR_HI_FRAME_RATE] = 1'b1; // R4
        // A colour variant can still hide white balance in modes marked in the map.
        high_o[`FIR_HI_WHITE_BAL] = (COLOR_VARIANT != 0) &&
            !WB_OFF_MAP[{format_i, mode_i}]; // R5 R2
        low_o = {`FIR_LO_FIELDS{1'b0}}; // R7
        opt_o = {`FIR_OPT_FIELDS{1'b0}};
        opt_o[`FIR_OPT_PARALLEL_IO] = 1'b1; // R8
        opt_o[`FIR_OPT_SERIAL_IO] = 1'b0; // R8
        opt_o[`FIR_OPT_STROBE] = 1'b1; // R8
    end

endmodule // fir_presence

//--- sim/fir_regs_props.sv
// Checker of bus timing and read values of the feature inquiry bank.
`timescale 1ns/100ps
`include "fir_map.vh"
module fir_regs_props #(
    parameter COLOR_VARIANT = 0,
    parameter [63:0] WB_OFF_MAP = 64'h0000_0000_0000_0000,
    parameter [31:0] VENDOR_PTR = `FIR_VENDOR_PTR_DEF,
    parameter [31:0] PIO_PTR = `FIR_PIO_PTR_DEF,
    parameter [31:0] STROBE_PTR = `FIR_STROBE_PTR_DEF
) (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [`FIR_ADR_W-1:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire [2:0] video_format_o,
    input wire [2:0] video_mode_o,
    input wire presence_changed_o
);
    // ------------------------------------------------------------------
    // Expected words
    // ------------------------------------------------------------------
    wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire rd_take = take && !wb_we_i;
    wire wb_on = (COLOR_VARIANT != 0) && !WB_OFF_MAP[{video_format_o, video_mode_o}];
    wire [31:0] high_exp = 32'h8189_0000 | (wb_on ? 32'h1000_0000 : 32'h0000_0000);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_rd(logic [11:0] a, logic [31:0] v);
        rd_take && wb_adr_i[11:2] == a[11:2] |=> wb_dat_o == v;
    endproperty
    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_ack_follows: assert property (take |=> wb_ack_o) else $error("ack missing");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_ack_cause: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("stray ack");
    a_dat_holds: assert property (!take |=> $stable(wb_dat_o)) else $error("data moved");
    a_high_word: assert property (p_rd(`FIR_OFF_FEAT_HIGH, high_exp))
        else $error("high presence word wrong");
    a_low_word: assert property (p_rd(`FIR_OFF_FEAT_LOW, `FIR_ZERO_WORD))
        else $error("low presence word wrong");
    a_opt_word: assert property (p_rd(`FIR_OFF_OPT_FUNC, 32'h5000_0000))
        else $error("optional word wrong");
    a_vendor_ptr: assert property (p_rd(`FIR_OFF_VENDOR_PTR, VENDOR_PTR))
        else $error("vendor pointer wrong");
    a_pio_ptr: assert property (p_rd(`FIR_OFF_PIO_PTR, PIO_PTR))
        else $error("parallel pointer wrong");
    a_strobe_ptr: assert property (p_rd(`FIR_OFF_STROBE_PTR, STROBE_PTR))
        else $error("strobe pointer wrong");
    c_high_read: cover property (rd_take && wb_adr_i == `FIR_OFF_FEAT_HIGH);
    c_inq_write: cover property (take && wb_we_i && wb_adr_i == `FIR_OFF_FEAT_HIGH);
    c_changed: cover property ($rose(presence_changed_o));
endmodule // fir_regs_props

bind fir_regs fir_regs_props #(
    .COLOR_VARIANT(COLOR_VARIANT),
    .WB_OFF_MAP(WB_OFF_MAP),
    .VENDOR_PTR(VENDOR_PTR),
    .PIO_PTR(PIO_PTR),
    .STROBE_PTR(STROBE_PTR)
) i_props (.*);

//--- sim/fir_regs_tb.sv
// Self-checking bench for the feature inquiry register bank.
`timescale 1ns/100ps
`include "fir_map.vh"
module fir_regs_tb;
    reg clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg wb_cyc_i = 1'b0;
    reg wb_stb_i = 1'b0;
    reg wb_we_i = 1'b0;
    reg [11:0] wb_adr_i = 12'h000;
    reg [3:0] wb_sel_i = 4'h0;
    reg [31:0] wb_dat_i = 32'h0000_0000;
    wire [31:0] wb_dat_o;
    wire wb_ack_o;
    wire [2:0] video_format_o;
    wire [2:0] video_mode_o;
    wire presence_changed_o;
    reg [31:0] rd_q;
    integer bad_count = 0;
    integer checked = 0;
    // Format 0, mode 1 hides white balance, so a selection change shows on the high word.
    fir_regs #(.COLOR_VARIANT(1), .WB_OFF_MAP(64'h0000_0000_0000_0002)) i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .video_format_o(video_format_o),
        .video_mode_o(video_mode_o), .presence_changed_o(presence_changed_o));
    always #20 clk_i = ~clk_i;
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task final_report;
        begin
            if (bad_count == 0 && checked > 0) $display("SIMULATION PASSED");
            else $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("[ERR] %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // Called right after a rising edge; returns one idle cycle after the ack edge.
    // Ack is watched on the falling edge, so the rising edge that launches it is never raced.
    task wb_xfer(input we, input [11:0] adr, input [3:0] sel, input [31:0] dat);
        integer n;
        begin
            wb_cyc_i <= 1'b1;
            wb_stb_i <= 1'b1;
            wb_we_i <= we;
            wb_adr_i <= adr;
            wb_sel_i <= sel;
            wb_dat_i <= dat;
            n = 0;
            @(negedge clk_i);
            while (wb_ack_o !== 1'b1 && n < 20) begin
                n = n + 1;
                @(negedge clk_i);
            end
            if (n == 20) chk(32'h0000_0000, 32'h0000_0001);
            @(posedge clk_i);
            rd_q = wb_dat_o;
            wb_cyc_i <= 1'b0;
            wb_stb_i <= 1'b0;
            @(posedge clk_i);
        end
    endtask
    task rd_chk(input [11:0] adr, input [31:0] exp);
        begin
            wb_xfer(1'b0, adr, 4'h0, 32'h0000_0000);
            chk(rd_q, exp);
        end
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task t_inquiry;
        begin
            rd_chk(`FIR_OFF_FEAT_HIGH, 32'h9189_0000);
            rd_chk(`FIR_OFF_FEAT_LOW, 32'h0000_0000);
            rd_chk(`FIR_OFF_OPT_FUNC, 32'h5000_0000);
            rd_chk(`FIR_OFF_VENDOR_PTR, `FIR_VENDOR_PTR_DEF);
            rd_chk(`FIR_OFF_PIO_PTR, `FIR_PIO_PTR_DEF);
            rd_chk(`FIR_OFF_STROBE_PTR, `FIR_STROBE_PTR_DEF);
            rd_chk(12'h410, 32'h0000_0000);
        end
    endtask
    task t_readonly;
        begin
            wb_xfer(1'b1, `FIR_OFF_FEAT_HIGH, 4'hF, 32'hFFFF_FFFF);
            wb_xfer(1'b1, `FIR_OFF_FEAT_LOW, 4'hF, 32'hFFFF_FFFF);
            wb_xfer(1'b1, `FIR_OFF_OPT_FUNC, 4'hF, 32'hFFFF_FFFF);
            wb_xfer(1'b1, `FIR_OFF_VENDOR_PTR, 4'hF, 32'hFFFF_FFFF);
            wb_xfer(1'b1, `FIR_OFF_PIO_PTR, 4'hF, 32'hFFFF_FFFF);
            wb_xfer(1'b1, `FIR_OFF_STROBE_PTR, 4'hF, 32'hFFFF_FFFF);
            t_inquiry();
        end
    endtask
    task t_select;
        begin
            wb_xfer(1'b1, `FIR_OFF_STATUS, 4'h1, 32'h0000_0001);
            rd_chk(`FIR_OFF_STATUS, 32'h0000_0002);
            wb_xfer(1'b1, `FIR_OFF_VIDEO_SEL, 4'h3, 32'h0000_0001);
            @(negedge clk_i);
            chk({26'h000_0000, video_format_o, video_mode_o}, 32'h0000_0001);
            chk({31'h0000_0000, presence_changed_o}, 32'h0000_0001);
            @(posedge clk_i);
            rd_chk(`FIR_OFF_FEAT_HIGH, 32'h8189_0000);
            rd_chk(`FIR_OFF_VIDEO_SEL, 32'h0000_0001);
            wb_xfer(1'b1, `FIR_OFF_VIDEO_SEL, 4'h3, 32'h0000_0700);
            rd_chk(`FIR_OFF_FEAT_HIGH, 32'h9189_0000);
        end
    endtask
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        t_inquiry();
        t_readonly();
        t_select();
        final_report();
    end
    initial begin
        #200000;
        bad_count = bad_count + 1;
        final_report();
    end
endmodule // fir_regs_tb
